// [hdl/alscd_pkg.sv]
package alscd_pkg;

	// Bus address and command set
	localparam logic [6:0] SLAVE_ADDR = 7'h39;
	localparam logic [7:0] CMD_CONV_START = 8'h00;
	localparam logic [7:0] CMD_CONV_FINISH = 8'h03;
	localparam logic [7:0] CMD_SEL_CLR0 = 8'h1d;
	localparam logic [7:0] CMD_SEL_DEFAULT = 8'h18;
	localparam logic [7:0] CMD_RD_LSB = 8'h43;
	localparam logic [7:0] CMD_RD_MSB = 8'h83;
	localparam logic [7:0] CMD_SEL_SET1 = 8'h88;
	localparam logic [7:0] CMD_SEL_SET2 = 8'h90;

	// Integration select field
	localparam int SEL_W = 3;
	localparam int SEL_BIT0 = 0;
	localparam int SEL_BIT1 = 1;
	localparam int SEL_BIT2 = 2;
	localparam logic [2:0] SEL_400 = 3'h0;
	localparam logic [2:0] SEL_200 = 3'h1;
	localparam logic [2:0] SEL_100 = 3'h2;
	localparam logic [2:0] SEL_TEST = 3'h3;
	localparam logic [2:0] SEL_SIM = 3'h4;
	localparam logic [2:0] SEL_RESET = SEL_200;

	// Widths
	localparam int COUNT_W = 16;
	localparam int TIMER_W = 26;
	localparam int BITCNT_W = 3;

	// Integration times and their cycle counts at 125 MHz
	localparam real CLK_PERIOD_NS = 8.0;
	localparam real T_400_MS = 400.0;
	localparam real T_200_MS = 200.0;
	localparam real T_100_MS = 100.0;
	localparam real T_TEST_MS = 16.7;
	localparam real T_SIM_MS = 1.0;
	localparam int CYC_400 = int'($floor(T_400_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int CYC_200 = int'($floor(T_200_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int CYC_100 = int'($floor(T_100_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int CYC_TEST = int'($floor(T_TEST_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int CYC_SIM = int'($floor(T_SIM_MS * 1.0e6 / CLK_PERIOD_NS));

	// Open-drain data pin drive
	typedef struct packed {
		logic o;
		logic oe;
	} alscd_pin_s;

	typedef enum {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WRITE,
		ST_WRITE_ACK,
		ST_READ,
		ST_READ_ACK,
		ST_WAIT_STOP
	} alscd_state_e;

endpackage

// [hdl/alscd_conv.sv]
`timescale 1ns/1ps
module alscd_conv #(
	parameter int CYC_400 = alscd_pkg::CYC_400,
	parameter int CYC_200 = alscd_pkg::CYC_200,
	parameter int CYC_100 = alscd_pkg::CYC_100,
	parameter int CYC_TEST = alscd_pkg::CYC_TEST,
	parameter int CYC_SIM = alscd_pkg::CYC_SIM
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Control
	input wire logic start,
	input wire logic finish,
	input wire logic [alscd_pkg::SEL_W-1:0] sel,
	// Front end
	input wire logic light_pulse,
	// Results
	output logic active,
	output logic [alscd_pkg::COUNT_W-1:0] count
);
	logic lp_s1_r;
	logic lp_s2_r;
	logic lp_d_r;
	logic [alscd_pkg::TIMER_W-1:0] timer_r;
	logic [alscd_pkg::TIMER_W-1:0] window;
	logic [alscd_pkg::COUNT_W-1:0] accum_r;
	logic active_r;
	logic [alscd_pkg::COUNT_W-1:0] count_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			lp_s1_r <= 1'b0;
			lp_s2_r <= 1'b0;
			lp_d_r <= 1'b0;
		end else begin
			lp_s1_r <= light_pulse;
			lp_s2_r <= lp_s1_r;
			lp_d_r <= lp_s2_r;
		end
	end

	// Reserved codes fall back to the default window rather than stall
	always_comb begin
		unique case (sel)
			alscd_pkg::SEL_400: window = alscd_pkg::TIMER_W'(CYC_400 - 1);
			alscd_pkg::SEL_100: window = alscd_pkg::TIMER_W'(CYC_100 - 1);
			alscd_pkg::SEL_TEST: window = alscd_pkg::TIMER_W'(CYC_TEST - 1);
			alscd_pkg::SEL_SIM: window = alscd_pkg::TIMER_W'(CYC_SIM - 1);
			default: window = alscd_pkg::TIMER_W'(CYC_200 - 1);
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			active_r <= 1'b0;
			timer_r <= '0;
		end else if (start) begin
			active_r <= 1'b1;
			timer_r <= '0;
		end else if (finish) begin
			active_r <= 1'b0;
		end else if (active_r && timer_r >= window) begin
			active_r <= 1'b0;
		end else if (active_r) begin
			timer_r <= timer_r + 1'b1;
		end
	end

	// Saturate instead of wrapping so bright light never reads as dark
	always_ff @(posedge clk) begin
		if (reset) begin
			accum_r <= '0;
		end else if (start) begin
			accum_r <= '0;
		end else if (active_r && lp_s2_r && !lp_d_r && !(&accum_r)) begin
			accum_r <= accum_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count_r <= '0;
		end else if (finish) begin
			count_r <= accum_r;
		end
	end

	assign active = active_r;
	assign count = count_r;
endmodule

// [hdl/alscd_top.sv]
`timescale 1ns/1ps
// Function
// - Select 000, 001, 010 integrate 400, 200, 100 ms.
// - Select resets to 001; command 0x18 restores 001.
// - Select 011 integrates 16.7 ms, 100 integrates 1.0 ms.
// - One data byte per transaction, write or read.
// - Only seven-bit address 0x39 is answered.
// - Command 0x00 starts a conversion.
// - Command 0x03 finishes the conversion and latches the count.
// - After 0x43 a read returns the count low byte.
// - After 0x83 a read returns the count high byte.
// - Command 0x1d clears select bit 0 only.
// - Command 0x88 sets select bit 1, 0x90 sets bit 2.
// - No repeated START; every transaction ends with STOP.
// - Write: ack address, then ack eight command bits, MSB first.
// - Read: ack address, send eight bits MSB first, master NACKs.
module alscd_top #(
	parameter int CYC_400 = alscd_pkg::CYC_400,
	parameter int CYC_200 = alscd_pkg::CYC_200,
	parameter int CYC_100 = alscd_pkg::CYC_100,
	parameter int CYC_TEST = alscd_pkg::CYC_TEST,
	parameter int CYC_SIM = alscd_pkg::CYC_SIM
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Serial bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output alscd_pkg::alscd_pin_s sda_drv,
	// Light front end
	input wire logic light_pulse,
	// Status
	output logic [alscd_pkg::SEL_W-1:0] integration_select,
	output logic conv_active
);
	logic scl_s1_r;
	logic scl_s2_r;
	logic scl_d_r;
	logic sda_s1_r;
	logic sda_s2_r;
	logic sda_d_r;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	alscd_pkg::alscd_state_e state_r;
	logic [alscd_pkg::BITCNT_W-1:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic ack_phase_r;
	logic rw_r;
	logic [7:0] cmd_byte_r;
	logic cmd_valid_r;
	alscd_pkg::alscd_pin_s pin_r;

	logic [alscd_pkg::SEL_W-1:0] sel_r;
	logic rd_msb_r;
	logic conv_start_r;
	logic conv_finish_r;
	logic [alscd_pkg::COUNT_W-1:0] count;
	logic [7:0] rd_byte;

	// Pins cross into the clk domain through two flops each
	always_ff @(posedge clk) begin
		if (reset) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_s1_r <= scl_i;
			scl_s2_r <= scl_s1_r;
			scl_d_r <= scl_s2_r;
			sda_s1_r <= sda_i;
			sda_s2_r <= sda_s1_r;
			sda_d_r <= sda_s2_r;
		end
	end

	assign scl_rise = scl_s2_r && !scl_d_r;
	assign scl_fall = !scl_s2_r && scl_d_r;
	assign start_det = scl_s2_r && scl_d_r && !sda_s2_r && sda_d_r;
	assign stop_det = scl_s2_r && scl_d_r && sda_s2_r && !sda_d_r;

	assign rd_byte = rd_msb_r ? count[15:8] : count[7:0];

	// Bus protocol engine; data changes only while the clock line is low
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= alscd_pkg::ST_IDLE;
			bit_cnt_r <= '0;
			shift_r <= 8'h00;
			ack_phase_r <= 1'b0;
			rw_r <= 1'b0;
			cmd_byte_r <= 8'h00;
			cmd_valid_r <= 1'b0;
			pin_r <= '0;
		end else begin
			cmd_valid_r <= 1'b0;
			pin_r.o <= 1'b0;
			if (stop_det) begin
				state_r <= alscd_pkg::ST_IDLE;
				pin_r.oe <= 1'b0;
			end else if (start_det) begin
				bit_cnt_r <= '0;
				pin_r.oe <= 1'b0;
				// Repeated START is not honoured; sit out until STOP
				if (state_r == alscd_pkg::ST_IDLE) begin
					state_r <= alscd_pkg::ST_ADDR;
				end else begin
					state_r <= alscd_pkg::ST_WAIT_STOP;
				end
			end else begin
				unique case (state_r)
					alscd_pkg::ST_IDLE: begin
					end
					alscd_pkg::ST_ADDR: begin
						if (scl_rise) begin
							shift_r <= {shift_r[6:0], sda_s2_r};
							bit_cnt_r <= bit_cnt_r + 1'b1;
							if (bit_cnt_r == 3'h7) begin
								ack_phase_r <= 1'b0;
								rw_r <= sda_s2_r;
								if (shift_r[6:0] == alscd_pkg::SLAVE_ADDR) begin
									state_r <= alscd_pkg::ST_ADDR_ACK;
								end else begin
									state_r <= alscd_pkg::ST_WAIT_STOP;
								end
							end
						end
					end
					alscd_pkg::ST_ADDR_ACK: begin
						if (scl_fall) begin
							if (!ack_phase_r) begin
								pin_r.oe <= 1'b1;
								ack_phase_r <= 1'b1;
							end else begin
								ack_phase_r <= 1'b0;
								bit_cnt_r <= '0;
								if (rw_r) begin
									shift_r <= rd_byte;
									pin_r.oe <= !rd_byte[7];
									state_r <= alscd_pkg::ST_READ;
								end else begin
									pin_r.oe <= 1'b0;
									state_r <= alscd_pkg::ST_WRITE;
								end
							end
						end
					end
					alscd_pkg::ST_WRITE: begin
						if (scl_rise) begin
							shift_r <= {shift_r[6:0], sda_s2_r};
							bit_cnt_r <= bit_cnt_r + 1'b1;
							if (bit_cnt_r == 3'h7) begin
								cmd_byte_r <= {shift_r[6:0], sda_s2_r};
								cmd_valid_r <= 1'b1;
								state_r <= alscd_pkg::ST_WRITE_ACK;
							end
						end
					end
					alscd_pkg::ST_WRITE_ACK: begin
						if (scl_fall) begin
							if (!ack_phase_r) begin
								pin_r.oe <= 1'b1;
								ack_phase_r <= 1'b1;
							end else begin
								pin_r.oe <= 1'b0;
								ack_phase_r <= 1'b0;
								// Further bytes go unacknowledged
								state_r <= alscd_pkg::ST_WAIT_STOP;
							end
						end
					end
					alscd_pkg::ST_READ: begin
						if (scl_fall) begin
							if (bit_cnt_r == 3'h7) begin
								pin_r.oe <= 1'b0;
								state_r <= alscd_pkg::ST_READ_ACK;
							end else begin
								bit_cnt_r <= bit_cnt_r + 1'b1;
								shift_r <= {shift_r[6:0], 1'b0};
								pin_r.oe <= !shift_r[6];
							end
						end
					end
					alscd_pkg::ST_READ_ACK: begin
						if (scl_rise) begin
							state_r <= alscd_pkg::ST_WAIT_STOP;
						end
					end
					alscd_pkg::ST_WAIT_STOP: begin
					end
				endcase
			end
		end
	end

	// Command decoder
	always_ff @(posedge clk) begin
		if (reset) begin
			sel_r <= alscd_pkg::SEL_RESET;
			rd_msb_r <= 1'b0;
			conv_start_r <= 1'b0;
			conv_finish_r <= 1'b0;
		end else begin
			conv_start_r <= 1'b0;
			conv_finish_r <= 1'b0;
			if (cmd_valid_r) begin
				unique case (cmd_byte_r)
					alscd_pkg::CMD_CONV_START: conv_start_r <= 1'b1;
					alscd_pkg::CMD_CONV_FINISH: conv_finish_r <= 1'b1;
					alscd_pkg::CMD_SEL_CLR0: sel_r[alscd_pkg::SEL_BIT0] <= 1'b0;
					alscd_pkg::CMD_SEL_DEFAULT: sel_r <= alscd_pkg::SEL_RESET;
					alscd_pkg::CMD_RD_LSB: rd_msb_r <= 1'b0;
					alscd_pkg::CMD_RD_MSB: rd_msb_r <= 1'b1;
					alscd_pkg::CMD_SEL_SET1: sel_r[alscd_pkg::SEL_BIT1] <= 1'b1;
					alscd_pkg::CMD_SEL_SET2: sel_r[alscd_pkg::SEL_BIT2] <= 1'b1;
					default: begin
					end
				endcase
			end
		end
	end

	alscd_conv #(
		.CYC_400(CYC_400),
		.CYC_200(CYC_200),
		.CYC_100(CYC_100),
		.CYC_TEST(CYC_TEST),
		.CYC_SIM(CYC_SIM)
	) u_conv (
		.clk(clk),
		.reset(reset),
		.start(conv_start_r),
		.finish(conv_finish_r),
		.sel(sel_r),
		.light_pulse(light_pulse),
		.active(conv_active),
		.count(count)
	);

	assign sda_drv = pin_r;
	assign integration_select = sel_r;
endmodule

// [verif/alscd_master.sv]
`timescale 1ns/1ps
module alscd_master (
	// Bus lines
	output logic scl,
	output logic sda_low,
	input wire logic sda,
	// Result
	output logic done,
	output logic [1:0] acks,
	output logic [7:0] rdata
);
	// Quarter of the 125 ns bus clock period
	realtime q = 31.25;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		done = 1'b0;
	end
	task automatic bit_io(input logic b, output logic s);
		sda_low = !b;
		#q scl = 1'b1;
		#q s = sda;
		#q scl = 1'b0;
		#q;
	endtask
	// Always one byte then STOP, so no repeated START is ever sent
	task automatic xfer(input logic [6:0] a, input logic rw, input logic [7:0] d);
		logic s;
		sda_low = 1'b1;
		#q scl = 1'b0;
		#q;
		for (int i = 7; i > 0; i--) bit_io(a[i-1], s);
		bit_io(rw, s);
		bit_io(1'b1, s);
		acks[1] = !s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(rw | d[i], s);
			rdata[i] = s;
		end
		bit_io(1'b1, s);
		acks[0] = !s;
		sda_low = 1'b1;
		#q scl = 1'b1;
		#q sda_low = 1'b0;
		#(4 * q) done = 1'b1;
		#1 done = 1'b0;
	endtask
endmodule

// [verif/alscd_checker.sv]
`timescale 1ns/1ps
module alscd_checker #(
	parameter int CYC_400 = alscd_pkg::CYC_400,
	parameter int CYC_200 = alscd_pkg::CYC_200,
	parameter int CYC_100 = alscd_pkg::CYC_100,
	parameter int CYC_TEST = alscd_pkg::CYC_TEST,
	parameter int CYC_SIM = alscd_pkg::CYC_SIM
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Watched ports
	input wire logic scl_i,
	input wire logic sda_i,
	input alscd_pkg::alscd_pin_s sda_drv,
	input wire logic light_pulse,
	input wire logic [alscd_pkg::SEL_W-1:0] integration_select,
	input wire logic conv_active
);
	// Select may change mid-run, so only the longest window bounds a run
	localparam int MAX_A = CYC_400 > CYC_200 ? CYC_400 : CYC_200;
	localparam int MAX_B = CYC_100 > CYC_TEST ? CYC_100 : CYC_TEST;
	localparam int MAX_C = MAX_A > MAX_B ? MAX_A : MAX_B;
	localparam int CYC_MAX = MAX_C > CYC_SIM ? MAX_C : CYC_SIM;
	int run_r;
	always_ff @(posedge clk) begin
		if (reset || !conv_active) run_r <= 0;
		else run_r <= run_r + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_rst; $fell(reset) |-> integration_select == 3'h1 && !sda_drv.oe && !conv_active;
	endproperty
	property p_sel_step; !$stable(integration_select) |-> integration_select == 3'h1
		|| integration_select == ($past(integration_select) & 3'h6)
		|| integration_select == ($past(integration_select) | 3'h2)
		|| integration_select == ($past(integration_select) | 3'h4);
	endproperty
	property p_sel_scl; !$stable(integration_select) |-> scl_i; endproperty
	property p_conv_scl; $rose(conv_active) |-> scl_i; endproperty
	property p_conv_min; $rose(conv_active) |=> conv_active [*8]; endproperty
	property p_conv_max; run_r <= CYC_MAX + 2; endproperty
	property p_oe_on; $rose(sda_drv.oe) |-> !scl_i; endproperty
	property p_oe_off; $fell(sda_drv.oe) |-> !scl_i; endproperty
	property p_oe_stand; $rose(sda_drv.oe) |=> sda_drv.oe [*3]; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	a_sel_step: assert property (p_sel_step) else $error("bad select step");
	a_sel_scl: assert property (p_sel_scl) else $error("select moved off byte");
	a_conv_scl: assert property (p_conv_scl) else $error("conversion start off byte");
	a_conv_min: assert property (p_conv_min) else $error("window too short");
	a_conv_max: assert property (p_conv_max) else $error("window too long");
	a_oe_on: assert property (p_oe_on) else $error("drive began with clock high");
	a_oe_off: assert property (p_oe_off) else $error("drive ended with clock high");
	a_oe_stand: assert property (p_oe_stand) else $error("drive too short");
	c_conv: cover property ($rose(conv_active));
	c_ack: cover property ($fell(sda_drv.oe));
	c_sim: cover property (integration_select == 3'h4);
endmodule
bind alscd_top alscd_checker #(.CYC_400(CYC_400), .CYC_200(CYC_200), .CYC_100(CYC_100),
	.CYC_TEST(CYC_TEST), .CYC_SIM(CYC_SIM)) alscd_checker_i (.clk(clk), .reset(reset),
	.scl_i(scl_i), .sda_i(sda_i), .sda_drv(sda_drv), .light_pulse(light_pulse),
	.integration_select(integration_select), .conv_active(conv_active));

// [verif/test_light_sensor_command_decoder.sv]
`timescale 1ns/1ps
module test_light_sensor_command_decoder;
	logic clk, reset, light_pulse, scl, sda_low, conv_active, done;
	logic [alscd_pkg::SEL_W-1:0] integration_select, sel_m;
	logic [1:0] acks;
	logic [7:0] rdata, c;
	alscd_pkg::alscd_pin_s sda_drv;
	logic [12:0] exp_q[$];
	logic [31:0] seed = 32'h4921;
	int err_total, samples_checked, run, win, n;
	int wins[5] = '{400, 4000, 100, 40, 20};
	// Pull-up on the data line
	wire sda = !(sda_low | sda_drv.oe);
	alscd_top #(.CYC_400(400), .CYC_200(4000), .CYC_100(100), .CYC_TEST(40), .CYC_SIM(20))
		alscd_top_i (.clk(clk), .reset(reset), .scl_i(scl), .sda_i(sda), .sda_drv(sda_drv),
		.light_pulse(light_pulse), .integration_select(integration_select),
		.conv_active(conv_active));
	alscd_master alscd_master_i (.scl(scl), .sda_low(sda_low), .sda(sda), .done(done),
		.acks(acks), .rdata(rdata));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [2:0] nsel(input logic [2:0] s, input logic [7:0] d);
		case (d)
			8'h18: return 3'h1;
			8'h1d: return s & 3'h6;
			8'h88: return s | 3'h2;
			8'h90: return s | 3'h4;
			default: return s;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic op(input logic [6:0] a, input logic rw, input logic [7:0] d, input logic [7:0] e);
		if (a == 7'h39 && !rw) sel_m = nsel(sel_m, d);
		exp_q.push_back({a == 7'h39, a == 7'h39 && !rw, sel_m, e});
		alscd_master_i.xfer(a, rw, d);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge done) chk("bus", {acks, integration_select, rdata}, exp_q.pop_front());
	always @(posedge clk) begin
		if (conv_active) run <= run + 1;
		else if (run != 0) begin
			if (win != 0) chk("window", 13'(run >= win && run <= win + 2), 13'h1);
			run <= 0;
		end
	end
	initial begin
		reset = 1'b1;
		light_pulse = 1'b0;
		win = 0;
		sel_m = 3'h1;
		repeat (5) @(posedge clk);
		#1 reset = 1'b0;
		repeat (4) @(posedge clk);
		for (int k = 0; k < 5; k++) begin
			op(7'h39, 1'b0, 8'h18, 8'h18);
			if (!k[0]) op(7'h39, 1'b0, 8'h1d, 8'h1d);
			if (k[1]) op(7'h39, 1'b0, 8'h88, 8'h88);
			if (k[2]) op(7'h39, 1'b0, 8'h90, 8'h90);
			win = wins[k];
			op(7'h39, 1'b0, 8'h00, 8'h00);
			repeat (win + 10) @(posedge clk);
			win = 0;
		end
		// Back to 001 first: from 100 a random 0x88 would land on a reserved code
		op(7'h39, 1'b0, 8'h18, 8'h18);
		// Bit 4 kept clear so no reserved select code is written
		repeat (6) begin
			c = 8'(rnd()) & 8'hef;
			op(7'h39, 1'b0, c, c);
		end
		op(7'h39, 1'b0, 8'h18, 8'h18);
		n = 256 + int'(rnd() % 512);
		op(7'h39, 1'b0, 8'h00, 8'h00);
		repeat (n) begin
			repeat (2) @(posedge clk);
			#1 light_pulse = 1'b1;
			repeat (2) @(posedge clk);
			#1 light_pulse = 1'b0;
		end
		op(7'h39, 1'b0, 8'h03, 8'h03);
		op(7'h39, 1'b0, 8'h43, 8'h43);
		op(7'h39, 1'b1, 8'hff, n[7:0]);
		op(7'h39, 1'b0, 8'h83, 8'h83);
		op(7'h39, 1'b1, 8'hff, n[15:8]);
		op(7'h3a, 1'b0, 8'h1d, 8'h1d);
		repeat (20) @(posedge clk);
		results();
	end
	initial begin
		#400000;
		err_total++;
		results();
	end
endmodule
